// *** design/iowd_top.sv ***
// io card watchdog: timeout counter, trip flag, pin detach, bus gate
// What this block does
// - hold 32-bit ns timeout, reset to one second, trip when it elapses
// - every service event restarts the full timeout count
// - on trip every pin leaves its owner, becomes pulled-up input
// - on trip host bus communication stops until cleared
// - trip leaves function instance state untouched, they keep running
// - clearing trip resumes bus and restores load-time pin setup
// - trip flag reads true after trip; host writes false to clear
// - pins without active function act as bidirectional gpio
// - gpio pins come up as inputs until configured
`timescale 1ns/1ns
module iowd_top
    import iowd_pkg::*;
(
    input  wire logic                                clk_sys_in,
    input  wire logic                                reset_in,
    input  wire logic                                service_in,
    input  wire logic                                timeout_wr_in,
    input  wire logic [iowd_pkg::IOWD_TIMEOUT_W-1:0] timeout_data_in,
    input  wire logic                                trip_clear_in,
    input  wire logic                                bus_req_in,
    input  wire logic [iowd_pkg::IOWD_PIN_COUNT-1:0] func_sel_in,
    input  wire logic [iowd_pkg::IOWD_PIN_COUNT-1:0] func_out_in,
    input  wire logic [iowd_pkg::IOWD_PIN_COUNT-1:0] func_oe_in,
    input  wire logic [iowd_pkg::IOWD_PIN_COUNT-1:0] gpio_out_in,
    input  wire logic [iowd_pkg::IOWD_PIN_COUNT-1:0] gpio_dir_in,
    input  wire logic [iowd_pkg::IOWD_PIN_COUNT-1:0] pin_in,
    output logic      [iowd_pkg::IOWD_TIMEOUT_W-1:0] trip_timeout_out,
    output logic                                     tripped_out,
    output logic                                     bus_grant_out,
    output logic      [iowd_pkg::IOWD_PIN_COUNT-1:0] pin_level_out,
    output logic      [iowd_pkg::IOWD_PIN_COUNT-1:0] pin_out,
    output logic      [iowd_pkg::IOWD_PIN_COUNT-1:0] pin_oe_out,
    output logic      [iowd_pkg::IOWD_PIN_COUNT-1:0] pin_pullup_out
);
    import iowd_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [IOWD_TIMEOUT_W-1:0] trip_timeout_reg;
    logic [IOWD_COUNT_W-1:0]   count_reg;
    iowd_state_t               state_reg;
    logic                      expire;
    logic [IOWD_PIN_COUNT-1:0] pin_meta_reg;
    logic [IOWD_PIN_COUNT-1:0] pin_sync_reg;

    assign expire = (state_reg == IOWD_ST_RUN) && (count_reg == IOWD_COUNT_W'(1)) && !service_in;

    // timeout value in ns, host writable
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
            trip_timeout_reg <= IOWD_TIMEOUT_RESET;
        else if (timeout_wr_in)
            trip_timeout_reg <= timeout_data_in;
    end

    // cycle countdown, reloaded on service or timeout write
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
            count_reg <= iowd_ns_to_cycles(IOWD_TIMEOUT_RESET);
        else if (service_in || timeout_wr_in)
            count_reg <= iowd_ns_to_cycles(timeout_wr_in ? timeout_data_in : trip_timeout_reg);
        else if (state_reg == IOWD_ST_TRIPPED)
            count_reg <= iowd_ns_to_cycles(trip_timeout_reg);
        else if (count_reg != IOWD_COUNT_W'(1))
            count_reg <= count_reg - IOWD_COUNT_W'(1);
    end

    // trip flag: expiry beats a clear in the same cycle
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
            state_reg <= IOWD_ST_RUN;
        else
        begin
            case (state_reg)
                IOWD_ST_RUN:
                    if (expire)
                        state_reg <= IOWD_ST_TRIPPED;
                IOWD_ST_TRIPPED:
                    if (trip_clear_in)
                        state_reg <= IOWD_ST_RUN;
                default:
                    state_reg <= IOWD_ST_RUN;
            endcase
        end
    end

    assign tripped_out      = (state_reg == IOWD_ST_TRIPPED);
    assign trip_timeout_out = trip_timeout_reg;
    // bus handshake gated while tripped
    assign bus_grant_out    = bus_req_in && !tripped_out;

    // ----------------------------------------
    // pin input synchroniser
    // ----------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            pin_meta_reg <= IOWD_PINS_ZERO;
            pin_sync_reg <= IOWD_PINS_ZERO;
        end
        else
        begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end
    assign pin_level_out = pin_sync_reg;

    // function instances are outside and never reset by a trip
    iowd_pin_mux u_mux (
        .clk_sys_in     (clk_sys_in),
        .reset_in       (reset_in),
        .tripped_in     (tripped_out),
        .func_sel_in    (func_sel_in),
        .func_out_in    (func_out_in),
        .func_oe_in     (func_oe_in),
        .gpio_out_in    (gpio_out_in),
        .gpio_dir_in    (gpio_dir_in),
        .pin_out        (pin_out),
        .pin_oe_out     (pin_oe_out),
        .pin_pullup_out (pin_pullup_out)
    );

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_trip_on_expire;
        @(posedge clk_sys_in) disable iff (reset_in)
        expire |=> tripped_out;
    endproperty
    a_trip_on_expire: assert property (p_trip_on_expire) else $error("no trip on expiry");

    property p_service_reload;
        @(posedge clk_sys_in) disable iff (reset_in)
        (service_in && !timeout_wr_in) |=> count_reg == iowd_ns_to_cycles($past(trip_timeout_reg));
    endproperty
    a_service_reload: assert property (p_service_reload) else $error("service did not reload");

    property p_detach;
        @(posedge clk_sys_in) disable iff (reset_in)
        tripped_out ##1 tripped_out |-> (pin_oe_out == IOWD_PINS_ZERO) && (&pin_pullup_out);
    endproperty
    a_detach: assert property (p_detach) else $error("pins driven while tripped");

    property p_bus_block;
        @(posedge clk_sys_in) disable iff (reset_in)
        tripped_out |-> !bus_grant_out;
    endproperty
    a_bus_block: assert property (p_bus_block) else $error("bus granted while tripped");

    property p_restore;
        @(posedge clk_sys_in) disable iff (reset_in)
        (!tripped_out && func_sel_in[0] && $stable(func_sel_in[0]) && $stable(func_oe_in[0]) && !$past(tripped_out))
            |=> pin_oe_out[0] == $past(func_oe_in[0]);
    endproperty
    a_restore: assert property (p_restore) else $error("pin not restored");

    property p_clear;
        @(posedge clk_sys_in) disable iff (reset_in)
        (tripped_out && trip_clear_in) |=> !tripped_out;
    endproperty
    a_clear: assert property (p_clear) else $error("clear ignored");

    property p_sticky;
        @(posedge clk_sys_in) disable iff (reset_in)
        (tripped_out && !trip_clear_in) |=> tripped_out;
    endproperty
    a_sticky: assert property (p_sticky) else $error("trip dropped without clear");

    property p_gpio;
        @(posedge clk_sys_in) disable iff (reset_in)
        (!tripped_out && !func_sel_in[1]) |=> (tripped_out || pin_oe_out[1] == $past(gpio_dir_in[1]));
    endproperty
    a_gpio: assert property (p_gpio) else $error("gpio direction lost");

    property p_decrement;
        @(posedge clk_sys_in) disable iff (reset_in)
        (!tripped_out && !service_in && !timeout_wr_in && count_reg > IOWD_COUNT_W'(1))
            |=> count_reg == $past(count_reg) - IOWD_COUNT_W'(1);
    endproperty
    a_decrement: assert property (p_decrement) else $error("count not decremented");

    property p_reset_input;
        @(posedge clk_sys_in)
        $past(reset_in) |-> pin_oe_out == IOWD_PINS_ZERO;
    endproperty
    a_reset_input: assert property (p_reset_input) else $error("pins not inputs after reset");
endmodule : iowd_top

// *** pkg/iowd_pkg.sv ***
// package: constants and types for the io card watchdog
package iowd_pkg;
    localparam int          IOWD_PIN_COUNT      = 72;
    localparam int          IOWD_TIMEOUT_W      = 32;
    localparam int          IOWD_CLK_HZ         = 10_000_000;
    localparam int          IOWD_CLK_PERIOD_NS  = 1_000_000_000 / IOWD_CLK_HZ;
    localparam logic [31:0] IOWD_TIMEOUT_RESET  = 32'h3b9a_ca00; // one second in ns
    localparam int          IOWD_COUNT_W        = 32;
    localparam logic [IOWD_PIN_COUNT-1:0] IOWD_PINS_ZERO = '0;
    localparam logic        IOWD_TRIP_RESET     = 1'b0;

    typedef enum logic [1:0] {
        IOWD_ST_RUN,
        IOWD_ST_TRIPPED
    } iowd_state_t;

    // nanoseconds to clock cycles, rounded down, at least one
    function automatic logic [IOWD_COUNT_W-1:0] iowd_ns_to_cycles(input logic [IOWD_TIMEOUT_W-1:0] ns);
        logic [IOWD_COUNT_W-1:0] c;
        c = IOWD_COUNT_W'(ns / IOWD_TIMEOUT_W'(IOWD_CLK_PERIOD_NS));
        if (c == '0)
            c = IOWD_COUNT_W'(1);
        return c;
    endfunction : iowd_ns_to_cycles
endpackage : iowd_pkg

// *** design/iowd_pin_mux.sv ***
// pin multiplexer: function instance or gpio, detached on trip
`timescale 1ns/1ns
module iowd_pin_mux
    import iowd_pkg::*;
(
    input  wire logic                      clk_sys_in,
    input  wire logic                      reset_in,
    input  wire logic                      tripped_in,
    input  wire logic [IOWD_PIN_COUNT-1:0] func_sel_in,
    input  wire logic [IOWD_PIN_COUNT-1:0] func_out_in,
    input  wire logic [IOWD_PIN_COUNT-1:0] func_oe_in,
    input  wire logic [IOWD_PIN_COUNT-1:0] gpio_out_in,
    input  wire logic [IOWD_PIN_COUNT-1:0] gpio_dir_in,
    output logic      [IOWD_PIN_COUNT-1:0] pin_out,
    output logic      [IOWD_PIN_COUNT-1:0] pin_oe_out,
    output logic      [IOWD_PIN_COUNT-1:0] pin_pullup_out
);
    genvar i;
    generate
        for (i = 0; i < IOWD_PIN_COUNT; i++)
        begin : g_pin
            // per pin owner select, all released on trip
            always_ff @(posedge clk_sys_in)
            begin
                if (reset_in || tripped_in)
                begin
                    pin_out[i]        <= 1'b0;
                    pin_oe_out[i]     <= 1'b0;
                    pin_pullup_out[i] <= 1'b1;
                end
                else if (func_sel_in[i])
                begin
                    pin_out[i]        <= func_out_in[i];
                    pin_oe_out[i]     <= func_oe_in[i];
                    pin_pullup_out[i] <= ~func_oe_in[i];
                end
                else
                begin
                    pin_out[i]        <= gpio_out_in[i];
                    pin_oe_out[i]     <= gpio_dir_in[i];
                    pin_pullup_out[i] <= ~gpio_dir_in[i];
                end
            end
        end
    endgenerate
endmodule : iowd_pin_mux

// *** tb/iowd_top_bench.sv ***
// testbench for the io card watchdog
`timescale 1ns/1ns
module iowd_top_bench;
    import iowd_pkg::*;
    localparam int P = IOWD_PIN_COUNT;
    logic         clk_sys_in = 1'b0;
    logic         reset_in   = 1'b1;
    logic         svc        = 1'b0;
    logic         twr        = 1'b0;
    logic         clr        = 1'b0;
    logic         req        = 1'b1;
    logic [31:0]  tdata      = '0;
    logic [31:0]  tto;
    logic [P-1:0] sel = '0, fo = '0, foe = '0, go = '0, gdir = '0, pin_in = '0;
    logic [P-1:0] lvl, po, poe, ppu;
    logic         trip, grant;
    logic [31:0]  tos [4] = '{32'h32, 32'h64, 32'h1c2, 32'h0};
    int           mismatches = 0, compares = 0, seed = 22, cyc = 0, n, k;

    iowd_top dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .service_in(svc), .timeout_wr_in(twr),
        .timeout_data_in(tdata), .trip_clear_in(clr), .bus_req_in(req), .func_sel_in(sel), .func_out_in(fo),
        .func_oe_in(foe), .gpio_out_in(go), .gpio_dir_in(gdir), .pin_in(pin_in), .trip_timeout_out(tto),
        .tripped_out(trip), .bus_grant_out(grant), .pin_level_out(lvl), .pin_out(po), .pin_oe_out(poe),
        .pin_pullup_out(ppu));

    // ---------------------------------------------
    // clock, hang limit, helpers
    // ---------------------------------------------
    always #50 clk_sys_in = ~clk_sys_in;

    // cut a hang short
    always @(posedge clk_sys_in)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            final_report();
        end
    end

    task automatic tick(input int c);
        repeat (c) @(negedge clk_sys_in);
    endtask : tick

    task automatic chk_bit(input logic a, input logic e);
        compares++;
        if (a !== e)
        begin
            mismatches++;
            $display("Error %0t got %h exp %h", $time, a, e);
        end
    endtask : chk_bit

    task automatic chk_vec(input logic [P-1:0] a, input logic [P-1:0] e);
        compares++;
        if (a !== e)
        begin
            mismatches++;
            $display("Error %0t got %h exp %h", $time, a, e);
        end
    endtask : chk_vec

    function automatic logic [P-1:0] rnd();
        return P'({$random(seed), $random(seed), $random(seed)});
    endfunction : rnd

    // owned pins follow their function, the rest act as gpio
    function automatic logic [P-1:0] exp_out();
        return (sel & fo) | (~sel & go);
    endfunction : exp_out

    function automatic logic [P-1:0] exp_oe();
        return (sel & foe) | (~sel & gdir);
    endfunction : exp_oe

    // timeout in clock cycles, never below one
    function automatic int exp_cycles(input logic [31:0] t);
        int c;
        c = int'(t / 32'(IOWD_CLK_PERIOD_NS));
        return (c == 0) ? 1 : c;
    endfunction : exp_cycles

    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report

    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial
    begin
        tick(3);
        chk_bit(trip, 1'b0);
        chk_vec(P'(tto), P'(IOWD_TIMEOUT_RESET));
        chk_vec(poe, '0);
        chk_vec(ppu, '1);
        reset_in = 1'b0;
        // random pin setups while running
        repeat (4)
        begin
            sel = rnd(); fo = rnd(); foe = rnd(); go = rnd(); gdir = rnd(); pin_in = rnd();
            tick(2);
            chk_vec(po, exp_out());
            chk_vec(poe, exp_oe());
            chk_vec(lvl, pin_in);
            chk_bit(grant, 1'b1);
        end
        tos[3] = 32'hc8 + ($unsigned($random(seed)) & 32'h1ff);
        foreach (tos[t])
        begin
            twr = 1'b1; tdata = tos[t];
            tick(1);
            twr = 1'b0;
            chk_vec(P'(tto), P'(tos[t]));
            n = exp_cycles(tos[t]);
            // services at random gaps up to a full period
            repeat (6)
            begin
                k = 1 + int'($unsigned($random(seed)) % n);
                for (int i = 1; i <= k; i++)
                begin
                    svc = (i == k);
                    tick(1);
                end
                chk_bit(trip, 1'b0);
            end
            svc = 1'b0;
            tick(n - 1);
            chk_bit(trip, 1'b0);
            tick(1);
            chk_bit(trip, 1'b1);
            chk_bit(grant, 1'b0);
            // functions keep running, service does not clear
            fo = rnd(); foe = rnd(); svc = 1'b1;
            tick(1);
            svc = 1'b0;
            tick(1);
            chk_bit(trip, 1'b1);
            chk_vec(poe, '0);
            chk_vec(ppu, '1);
            chk_vec(po, '0);
            // host keeps servicing across the clear so a short period cannot expire
            clr = 1'b1;
            svc = 1'b1;
            tick(1);
            clr = 1'b0;
            chk_bit(trip, 1'b0);
            chk_bit(grant, 1'b1);
            tick(1);
            chk_vec(po, exp_out());
            chk_vec(poe, exp_oe());
            chk_vec(ppu, ~exp_oe());
            chk_bit(trip, 1'b0);
        end
        final_report();
    end
endmodule : iowd_top_bench
